// >>> hw/ncap_pkg.sv
package ncap_pkg;

  // clock and pin timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SYNC_STAGES = 2;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_RP_NS = 12;
  localparam int T_REH_NS = 10;
  localparam int T_REA_NS = 20;
  localparam int T_WB_NS = 100;
  localparam int T_GAP_NS = 100;

  localparam logic [7:0] WE_LOW_CYC = 8'((T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WE_HIGH_CYC = 8'((T_WH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RE_HIGH_CYC =
    8'((T_REH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // low phase covers access time plus the input synchroniser
  localparam logic [7:0] RE_LOW_CYC = 8'((((T_REA_NS > T_RP_NS ? T_REA_NS : T_RP_NS) * 1000
    + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + SYNC_STAGES + 1);
  localparam logic [7:0] WB_CYC = 8'(((T_WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS)
    + SYNC_STAGES);
  // one gap covers address-to-data, write-to-read and read-to-write spacing
  localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_READ_CB_GO = 8'h35;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG_GO = 8'h15;
  localparam logic [7:0] CMD_CB_PROG_SETUP = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_RAND_IN = 8'h85;
  localparam logic [7:0] CMD_RAND_OUT_SETUP = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_GO = 8'hE0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CACHE_READ = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;

  localparam int ADDR_W = 28;
  localparam int LEN_W = 12;
  localparam logic [LEN_W-1:0] PAGE_BYTES = 12'h0840;

  typedef enum logic [3:0] {
    OP_READ, OP_READ_CB, OP_READ_ID, OP_RESET, OP_PROG, OP_CACHE_PROG, OP_CB_PROG,
    OP_ERASE, OP_RAND_IN, OP_RAND_OUT, OP_STATUS, OP_CACHE_READ, OP_CACHE_LAST
  } ncap_op_t;

  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_WDATA, CYC_RDATA} ncap_kind_t;

  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic has2;
    logic [1:0] a_first;
    logic [2:0] a_num;
    logic wr;
    logic rd;
    logic bsy;
  } ncap_seq_t;

  function automatic ncap_seq_t ncap_decode(input ncap_op_t op);
    ncap_seq_t s;
    s = '0;
    unique case (op)
      OP_READ: s = '{CMD_READ_SETUP, CMD_READ_GO, 1'b1, 2'h0, 3'h4, 1'b0, 1'b1, 1'b1};
      OP_READ_CB: s = '{CMD_READ_SETUP, CMD_READ_CB_GO, 1'b1, 2'h0, 3'h4, 1'b0, 1'b0, 1'b1};
      OP_READ_ID: s = '{CMD_READ_ID, 8'h00, 1'b0, 2'h0, 3'h1, 1'b0, 1'b1, 1'b0};
      OP_RESET: s = '{CMD_RESET, 8'h00, 1'b0, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1};
      OP_PROG: s = '{CMD_PROG_SETUP, CMD_PROG_GO, 1'b1, 2'h0, 3'h4, 1'b1, 1'b0, 1'b1};
      OP_CACHE_PROG:
        s = '{CMD_PROG_SETUP, CMD_CACHE_PROG_GO, 1'b1, 2'h0, 3'h4, 1'b1, 1'b0, 1'b1};
      OP_CB_PROG: s = '{CMD_CB_PROG_SETUP, CMD_PROG_GO, 1'b1, 2'h0, 3'h4, 1'b0, 1'b0, 1'b1};
      OP_ERASE: s = '{CMD_ERASE_SETUP, CMD_ERASE_GO, 1'b1, 2'h2, 3'h2, 1'b0, 1'b0, 1'b1};
      OP_RAND_IN: s = '{CMD_RAND_IN, 8'h00, 1'b0, 2'h0, 3'h2, 1'b1, 1'b0, 1'b0};
      OP_RAND_OUT:
        s = '{CMD_RAND_OUT_SETUP, CMD_RAND_OUT_GO, 1'b1, 2'h0, 3'h2, 1'b0, 1'b1, 1'b0};
      OP_STATUS: s = '{CMD_STATUS, 8'h00, 1'b0, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0};
      OP_CACHE_READ: s = '{CMD_CACHE_READ, 8'h00, 1'b0, 2'h0, 3'h0, 1'b0, 1'b1, 1'b1};
      OP_CACHE_LAST: s = '{CMD_CACHE_LAST, 8'h00, 1'b0, 2'h0, 3'h0, 1'b0, 1'b1, 1'b1};
      default: s = '0;
    endcase
    return s;
  endfunction : ncap_decode

endpackage : ncap_pkg

// >>> hw/ncap_cyc_if.sv
`timescale 1ns/100ps
interface ncap_cyc_if;
  import ncap_pkg::*;
  logic req;
  ncap_kind_t kind;
  logic [7:0] wbyte;
  logic done;
  logic [7:0] rbyte;
  logic [7:0] io_in;
  logic cle;
  logic ale;
  logic we_n;
  logic re_n;
  logic [7:0] io_out;
  logic io_oe;

  modport ctrl (output req, output kind, output wbyte, output io_in,
    input done, input rbyte, input cle, input ale, input we_n, input re_n,
    input io_out, input io_oe);
  modport eng (input req, input kind, input wbyte, input io_in,
    output done, output rbyte, output cle, output ale, output we_n, output re_n,
    output io_out, output io_oe);
endinterface : ncap_cyc_if

// >>> hw/ncap_cycle.sv
`timescale 1ns/100ps
module ncap_cycle
  import ncap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  ncap_cyc_if.eng cyc
);

  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} ncap_cst_t;

  ncap_cst_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic cle_r, cle_nxt, ale_r, ale_nxt, we_n_r, we_n_nxt, re_n_r, re_n_nxt;
  logic oe_r, oe_nxt, rd_r, rd_nxt, done_r, done_nxt;
  logic [7:0] io_r, io_nxt, rbyte_r, rbyte_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cle_nxt = cle_r;
    ale_nxt = ale_r;
    we_n_nxt = we_n_r;
    re_n_nxt = re_n_r;
    oe_nxt = oe_r;
    rd_nxt = rd_r;
    io_nxt = io_r;
    rbyte_nxt = rbyte_r;
    done_nxt = 1'b0;
    unique case (st_r)
      C_IDLE: begin
        if (cyc.req) begin
          st_nxt = C_LOW;
          rd_nxt = (cyc.kind == CYC_RDATA);
          if (cyc.kind == CYC_RDATA) begin
            re_n_nxt = 1'b0;
            oe_nxt = 1'b0;
            cnt_nxt = RE_LOW_CYC - 8'h01;
          end else begin
            cle_nxt = (cyc.kind == CYC_CMD);
            ale_nxt = (cyc.kind == CYC_ADDR);
            we_n_nxt = 1'b0;
            io_nxt = cyc.wbyte;
            oe_nxt = 1'b1;
            cnt_nxt = WE_LOW_CYC - 8'h01;
          end
        end
      end
      C_LOW: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (rd_r) begin
          rbyte_nxt = cyc.io_in;
          re_n_nxt = 1'b1;
          cnt_nxt = RE_HIGH_CYC - 8'h01;
          st_nxt = C_HIGH;
        end else begin
          // rising strobe edge latches the byte; latch lines held through high phase
          we_n_nxt = 1'b1;
          cnt_nxt = WE_HIGH_CYC - 8'h01;
          st_nxt = C_HIGH;
        end
      end
      C_HIGH: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          cle_nxt = 1'b0;
          ale_nxt = 1'b0;
          oe_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= C_IDLE;
      cnt_r <= 8'h00;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      oe_r <= 1'b0;
      rd_r <= 1'b0;
      io_r <= 8'h00;
      rbyte_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cle_r <= cle_nxt;
      ale_r <= ale_nxt;
      we_n_r <= we_n_nxt;
      re_n_r <= re_n_nxt;
      oe_r <= oe_nxt;
      rd_r <= rd_nxt;
      io_r <= io_nxt;
      rbyte_r <= rbyte_nxt;
      done_r <= done_nxt;
    end
  end

  assign cyc.done = done_r;
  assign cyc.rbyte = rbyte_r;
  assign cyc.cle = cle_r;
  assign cyc.ale = ale_r;
  assign cyc.we_n = we_n_r;
  assign cyc.re_n = re_n_r;
  assign cyc.io_out = io_r;
  assign cyc.io_oe = oe_r;

endmodule : ncap_cycle

// >>> hw/ncap_top.sv
`timescale 1ns/100ps
module ncap_top
  import ncap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire ncap_op_t op_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [LEN_W-1:0] len_i,
  input wire logic [7:0] wdata_i,
  input wire logic wvalid_i,
  input wire logic wp_en_i,
  input wire logic [7:0] io_i,
  input wire logic rb_i,
  output logic [7:0] io_o,
  output logic io_oe_o,
  output logic cle_o,
  output logic ale_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic read_strobe_n_o,
  output logic wp_n_o,
  output logic busy_o,
  output logic done_o,
  output logic ready_o,
  output logic wready_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WB, S_BUSY, S_RDATA, S_END
  } ncap_st_t;

  ncap_cyc_if cyc ();

  ncap_cycle u_cycle (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cyc(cyc)
  );

  logic [7:0] io_s1_r, io_s2_r;
  logic rb_s1_r, rb_s2_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
      rb_s1_r <= rb_i;
      rb_s2_r <= rb_s1_r;
    end
  end

  assign cyc.io_in = io_s2_r;

  ncap_st_t st_r, st_nxt;
  ncap_seq_t seq_r, seq_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] aidx_r, aidx_nxt;
  logic [2:0] anum_r, anum_nxt;
  logic ce_n_r, ce_n_nxt, wp_n_r, busy_r, busy_nxt, done_r, done_nxt;
  logic wready_r, wready_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] abyte;

  // column bytes then row bytes, upper nibble of second byte low
  always_comb begin
    unique case (aidx_r)
      2'h0: abyte = addr_r[7:0];
      2'h1: abyte = {4'h0, addr_r[11:8]};
      2'h2: abyte = addr_r[19:12];
      2'h3: abyte = addr_r[27:20];
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    seq_nxt = seq_r;
    addr_nxt = addr_r;
    len_nxt = len_r;
    cnt_nxt = cnt_r;
    aidx_nxt = aidx_r;
    anum_nxt = anum_r;
    ce_n_nxt = ce_n_r;
    busy_nxt = busy_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    wready_nxt = 1'b0;
    rvalid_nxt = 1'b0;
    cyc.req = 1'b0;
    cyc.kind = CYC_CMD;
    cyc.wbyte = 8'h00;
    if (st_r != S_IDLE && cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
    unique case (st_r)
      S_IDLE: begin
        if (start_i) begin
          seq_nxt = ncap_decode(op_i);
          addr_nxt = addr_i;
          len_nxt = (len_i > PAGE_BYTES) ? PAGE_BYTES : len_i;
          ce_n_nxt = 1'b0;
          busy_nxt = 1'b1;
          cnt_nxt = GAP_CYC;
          st_nxt = S_CMD1;
        end
      end
      S_CMD1: begin
        // the engine is idle again on the done edge; hold off or the byte goes out twice
        cyc.req = (cnt_r == 8'h00) && !cyc.done;
        cyc.wbyte = seq_r.c1;
        if (cyc.done) begin
          aidx_nxt = seq_r.a_first;
          anum_nxt = seq_r.a_num;
          // exactly the count this command needs
          if (seq_r.a_num != 3'h0) begin
            st_nxt = S_ADDR;
          end else if (seq_r.bsy && !seq_r.has2) begin
            cnt_nxt = WB_CYC;
            st_nxt = S_WB;
          end else if (seq_r.rd) begin
            cnt_nxt = GAP_CYC;
            st_nxt = S_RDATA;
          end else begin
            st_nxt = S_END;
          end
        end
      end
      S_ADDR: begin
        cyc.req = !cyc.done;
        cyc.kind = CYC_ADDR;
        cyc.wbyte = abyte;
        if (cyc.done) begin
          aidx_nxt = aidx_r + 2'h1;
          anum_nxt = anum_r - 3'h1;
          cnt_nxt = GAP_CYC;
          if (anum_r == 3'h1) begin
            if (seq_r.wr && len_r != '0) begin
              st_nxt = S_WDATA;
            end else if (seq_r.has2) begin
              st_nxt = S_CMD2;
            end else if (seq_r.rd) begin
              st_nxt = S_RDATA;
            end else begin
              st_nxt = S_END;
            end
          end
        end
      end
      S_WDATA: begin
        // wait out the accept pulse so the source can present the next byte
        cyc.req = (cnt_r == 8'h00) && wvalid_i && !cyc.done && !wready_r;
        cyc.kind = CYC_WDATA;
        cyc.wbyte = wdata_i;
        if (cyc.done) begin
          wready_nxt = 1'b1;
          len_nxt = len_r - 12'h001;
          if (len_r == 12'h001) begin
            st_nxt = seq_r.has2 ? S_CMD2 : S_END;
          end
        end
      end
      S_CMD2: begin
        cyc.req = (cnt_r == 8'h00) && !cyc.done;
        cyc.wbyte = seq_r.c2;
        if (cyc.done) begin
          if (seq_r.bsy) begin
            cnt_nxt = WB_CYC;
            st_nxt = S_WB;
          end else begin
            cnt_nxt = GAP_CYC;
            st_nxt = seq_r.rd ? S_RDATA : S_END;
          end
        end
      end
      S_WB: begin
        if (cnt_r == 8'h00) begin
          st_nxt = S_BUSY;
        end
      end
      S_BUSY: begin
        if (rb_s2_r) begin
          cnt_nxt = GAP_CYC;
          st_nxt = seq_r.rd ? S_RDATA : S_END;
        end
      end
      S_RDATA: begin
        cyc.req = (cnt_r == 8'h00) && (len_r != '0) && !cyc.done;
        cyc.kind = CYC_RDATA;
        if (len_r == '0) begin
          st_nxt = S_END;
        end else if (cyc.done) begin
          rdata_nxt = cyc.rbyte;
          rvalid_nxt = 1'b1;
          len_nxt = len_r - 12'h001;
        end
      end
      S_END: begin
        // select dropped only after busy ends
        ce_n_nxt = 1'b1;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= S_IDLE;
      seq_r <= '0;
      addr_r <= '0;
      len_r <= '0;
      cnt_r <= 8'h00;
      aidx_r <= 2'h0;
      anum_r <= 3'h0;
      ce_n_r <= 1'b1;
      wp_n_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      wready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      seq_r <= seq_nxt;
      addr_r <= addr_nxt;
      len_r <= len_nxt;
      cnt_r <= cnt_nxt;
      aidx_r <= aidx_nxt;
      anum_r <= anum_nxt;
      ce_n_r <= ce_n_nxt;
      wp_n_r <= ~wp_en_i;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      wready_r <= wready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign io_o = cyc.io_out;
  assign io_oe_o = cyc.io_oe;
  assign cle_o = cyc.cle;
  assign ale_o = cyc.ale;
  assign we_n_o = cyc.we_n;
  assign read_strobe_n_o = cyc.re_n;
  assign ce_n_o = ce_n_r;
  assign wp_n_o = wp_n_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign ready_o = rb_s2_r;
  assign wready_o = wready_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;

endmodule : ncap_top

// >>> bench/ncap_assertions.sv
`timescale 1ns/100ps
module ncap_assertions
  import ncap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wp_en_i,
  input wire logic [7:0] io_o,
  input wire logic io_oe_o,
  input wire logic cle_o,
  input wire logic ale_o,
  input wire logic ce_n_o,
  input wire logic we_n_o,
  input wire logic read_strobe_n_o,
  input wire logic wp_n_o,
  input wire logic done_o,
  input wire logic ready_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_excl;
    cle_o |-> !ale_o;
  endproperty
  a_excl: assert property (p_excl) else $error("both latches high");
  property p_we;
    $fell(we_n_o) |-> !we_n_o [*3] ##1 we_n_o [*2];
  endproperty
  a_we: assert property (p_we) else $error("write strobe shape");
  property p_hold;
    $rose(we_n_o) |-> io_oe_o && $stable(io_o) && $stable(cle_o) && $stable(ale_o);
  endproperty
  a_hold: assert property (p_hold) else $error("latch not held");
  property p_bsy;
    $rose(we_n_o) && cle_o && !ready_o |-> io_o == 8'hFF || io_o == 8'h70;
  endproperty
  a_bsy: assert property (p_bsy) else $error("command while busy");
  property p_rd;
    $fell(read_strobe_n_o) |-> !read_strobe_n_o [*7] ##1 read_strobe_n_o [*2];
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe shape");
  property p_rbus;
    !read_strobe_n_o |-> !io_oe_o && !cle_o && !ale_o && !ce_n_o;
  endproperty
  a_rbus: assert property (p_rbus) else $error("bus driven in read");
  property p_wp;
    $past(rst_n_i) |-> wp_n_o == !$past(wp_en_i);
  endproperty
  a_wp: assert property (p_wp) else $error("protect pin wrong");
  property p_done;
    done_o |-> ready_o ##1 !done_o;
  endproperty
  a_done: assert property (p_done) else $error("done while busy");
endmodule : ncap_assertions

// >>> bench/ncap_model.sv
`timescale 1ns/100ps
module ncap_model
  import ncap_pkg::*;
(
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic read_strobe_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic rb_o
);
  logic [7:0] cq[$];
  logic [7:0] aq[$];
  logic [7:0] dq[$];
  logic we_d = 1'b1;
  logic re_d = 1'b1;
  logic [11:0] col = 12'h000;
  int acnt = 0;
  int bsy = 0;
  int n_bad = 0;
  int n_wp = 0;
  initial io_o = 8'h00;
  // open drain, pulled up when released
  assign rb_o = (bsy == 0);
  always @(posedge clk_i) begin
    we_d <= we_n_i;
    re_d <= read_strobe_n_i;
    if (bsy > 0) bsy <= bsy - 1;
    if (!we_d && we_n_i && !ce_n_i) begin
      if (cle_i) begin
        cq.push_back(io_i);
        acnt <= 0;
        if (bsy > 0 && io_i != 8'hFF && io_i != 8'h70) n_bad <= n_bad + 1;
        if (!wp_n_i && io_i inside {8'h10, 8'h15, 8'hD0}) n_wp <= n_wp + 1;
        else if (io_i inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF, 8'h31, 8'h3F}) bsy <= 40;
      end else if (ale_i) begin
        aq.push_back(io_i);
        acnt <= acnt + 1;
        if (acnt == 0) col <= {4'h0, io_i};
        if (acnt == 1) col[11:8] <= io_i[3:0];
      end else begin
        dq.push_back(io_i);
      end
    end
    if (re_d && !read_strobe_n_i && !ce_n_i) begin
      io_o <= col[7:0];
      col <= (col == PAGE_BYTES - 12'h001) ? 12'h000 : col + 12'h001;
    end else if (read_strobe_n_i || ce_n_i) begin
      io_o <= ~io_o;
    end
  end
endmodule : ncap_model

// >>> bench/test_ncap_top.sv
`timescale 1ns/100ps
module test_ncap_top;
  import ncap_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  ncap_op_t op_i = OP_RESET;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [LEN_W-1:0] len_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wvalid_i = 1'b0;
  logic wp_en_i = 1'b0;
  logic [7:0] io_i, io_o, dev_io, rdata_o;
  logic rb_i, io_oe_o, cle_o, ale_o, ce_n_o, we_n_o, read_strobe_n_o, wp_n_o;
  logic busy_o, done_o, ready_o, wready_o, rvalid_o;
  logic [7:0] rd_q[$];
  int errors = 0;
  int tests_run = 0;
  assign io_i = io_oe_o ? io_o : dev_io;

  ncap_top u_ncap_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i), .addr_i(addr_i),
    .len_i(len_i), .wdata_i(wdata_i), .wvalid_i(wvalid_i), .wp_en_i(wp_en_i), .io_i(io_i),
    .rb_i(rb_i), .io_o(io_o), .io_oe_o(io_oe_o), .cle_o(cle_o), .ale_o(ale_o),
    .ce_n_o(ce_n_o), .we_n_o(we_n_o), .read_strobe_n_o(read_strobe_n_o), .wp_n_o(wp_n_o),
    .busy_o(busy_o), .done_o(done_o), .ready_o(ready_o), .wready_o(wready_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o)
  );
  ncap_model u_ncap_model (
    .clk_i(clk_i), .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
    .read_strobe_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .io_i(io_i), .io_o(dev_io),
    .rb_o(rb_i)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic start_op(input ncap_op_t op, input logic [ADDR_W-1:0] a,
      input logic [LEN_W-1:0] n);
    @(posedge clk_i);
    u_ncap_model.cq.delete();
    u_ncap_model.aq.delete();
    u_ncap_model.dq.delete();
    rd_q.delete();
    op_i <= op;
    addr_i <= a;
    len_i <= n;
    wdata_i <= 8'hA0;
    wvalid_i <= 1'b1;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
  endtask : start_op

  task automatic wait_done();
    int t;
    t = 0;
    while (done_o !== 1'b1) begin
      @(posedge clk_i);
      t++;
      if (wready_o === 1'b1) wdata_i <= wdata_i + 8'h01;
      if (rvalid_o === 1'b1) rd_q.push_back(rdata_o);
      if (t > 20000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask : wait_done

  task automatic op_cmds(input ncap_op_t op, input logic [7:0] c1, input logic [7:0] c2,
      input logic [7:0] na);
    start_op(op, 28'h123_4567, 12'h000);
    wait_done();
    chk(8'(u_ncap_model.cq.size()), (c2 == 8'h00) ? 8'h01 : 8'h02);
    chk(u_ncap_model.cq[0], c1);
    chk(u_ncap_model.cq[$], (c2 == 8'h00) ? c1 : c2);
    chk(8'(u_ncap_model.aq.size()), na);
  endtask : op_cmds

  task automatic s_cmd_set();
    op_cmds(OP_RESET, 8'hFF, 8'h00, 8'h00);
    op_cmds(OP_READ_ID, 8'h90, 8'h00, 8'h01);
    op_cmds(OP_STATUS, 8'h70, 8'h00, 8'h00);
    op_cmds(OP_READ, 8'h00, 8'h30, 8'h04);
    op_cmds(OP_READ_CB, 8'h00, 8'h35, 8'h04);
    op_cmds(OP_PROG, 8'h80, 8'h10, 8'h04);
    op_cmds(OP_CACHE_PROG, 8'h80, 8'h15, 8'h04);
    op_cmds(OP_CB_PROG, 8'h85, 8'h10, 8'h04);
    op_cmds(OP_ERASE, 8'h60, 8'hD0, 8'h02);
    op_cmds(OP_RAND_IN, 8'h85, 8'h00, 8'h02);
    op_cmds(OP_RAND_OUT, 8'h05, 8'hE0, 8'h02);
    op_cmds(OP_CACHE_READ, 8'h31, 8'h00, 8'h00);
    op_cmds(OP_CACHE_LAST, 8'h3F, 8'h00, 8'h00);
  endtask : s_cmd_set

  task automatic s_read();
    logic [ADDR_W-1:0] a;
    a = 28'hABC_D83E;
    start_op(OP_READ, a, 12'h003);
    wait_done();
    chk(u_ncap_model.aq[0], a[7:0]);
    chk(u_ncap_model.aq[1], {4'h0, a[11:8]});
    chk(u_ncap_model.aq[2], a[19:12]);
    chk(u_ncap_model.aq[3], a[27:20]);
    for (int i = 0; i < 3; i++) begin
      chk(rd_q[i], 8'((a[11:0] + i) % PAGE_BYTES));
    end
  endtask : s_read

  task automatic s_prog();
    start_op(OP_PROG, 28'h001_2000, 12'h003);
    wait_done();
    chk(u_ncap_model.cq[1], 8'h10);
    for (int i = 0; i < 3; i++) begin
      chk(u_ncap_model.dq[i], 8'hA0 + 8'(i));
    end
  endtask : s_prog

  task automatic s_wp();
    @(posedge clk_i);
    wp_en_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({7'h00, wp_n_o}, 8'h00);
    start_op(OP_ERASE, 28'hABC_D000, 12'h000);
    wait_done();
    chk(8'(u_ncap_model.n_wp), 8'h01);
    chk(u_ncap_model.aq[0], 8'hCD);
    chk(u_ncap_model.aq[1], 8'hAB);
    wp_en_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({7'h00, wp_n_o}, 8'h01);
  endtask : s_wp

  task automatic s_refuse();
    start_op(OP_ERASE, 28'h000_1000, 12'h000);
    // device is busy from about 66 to 106 cycles after the start edge
    repeat (80) @(posedge clk_i);
    chk({5'h00, busy_o, ce_n_o, rb_i}, 8'h04);
    op_i <= OP_STATUS;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    wait_done();
    repeat (40) @(posedge clk_i);
    chk(8'(u_ncap_model.cq.size()), 8'h02);
  endtask : s_refuse

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_cmd_set();
    s_read();
    s_prog();
    s_wp();
    s_refuse();
    chk(8'(u_ncap_model.n_bad), 8'h00);
    report_and_stop();
  end
endmodule : test_ncap_top

bind ncap_top ncap_assertions u_ncap_assertions (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wp_en_i(wp_en_i), .io_o(io_o), .io_oe_o(io_oe_o),
  .cle_o(cle_o), .ale_o(ale_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
  .read_strobe_n_o(read_strobe_n_o), .wp_n_o(wp_n_o), .done_o(done_o), .ready_o(ready_o)
);
